/* File: hw/drf_regs.vh */
`ifndef DRF_REGS_VH
`define DRF_REGS_VH

// register byte offsets
`define DRF_CTRL_OFF       8'h00
`define DRF_STATUS_OFF     8'h04
`define DRF_INT_STAT_OFF   8'h08
`define DRF_INT_MASK_OFF   8'h0C

// control fields
`define DRF_CTRL_FIFO_BIT  0
`define DRF_CTRL_PIPE_BIT  1
`define DRF_CTRL_WPOL_BIT  2
`define DRF_CTRL_RPOL_BIT  3
`define DRF_CTRL_CLR_BIT   4
`define DRF_CTRL_W         5
`define DRF_CTRL_RST       5'h00

// status fields
`define DRF_ST_FULL_BIT    0
`define DRF_ST_EMPTY_BIT   1
`define DRF_ST_ALMOST_FULL_FLAG_BIT   2
`define DRF_ST_ALMOST_EMPTY_FLAG_BIT  3

// interrupt fields
`define DRF_IRQ_OVF_BIT    0
`define DRF_IRQ_UNF_BIT    1
`define DRF_IRQ_FULL_BIT   2
`define DRF_IRQ_W          3
`define DRF_IRQ_RST        3'h0

// block geometry
`define DRF_BLK_BITS       4608
`define DRF_BLK_DEPTH      4096
`define DRF_BLK_AW         12
`define DRF_MAX_CASC       16

// port clock limit, MHz
`define DRF_MAX_PORT_MHZ   500

`endif

/* File: hw/drf_fifo_block.v */
// Overview of operation
// - The block holds 4,608 bits and is set by software to act as plain RAM or as a FIFO.
// - Writes and reads are synchronous, captured and produced on edges of their port clock.
// - Write and read ports run from separate independent clocks, each rated to 500 MHz.
// - In FIFO mode internal control makes the addresses and drives full, empty, almost-full and almost-empty.
// - FIFO pointers cross clock domains safely and writes are blocked when full, reads when empty.
// - In RAM mode user logic supplies both addresses and the FIFO controller is ignored.
// - In FIFO mode the controller addresses are multiplexed onto the array in place of the external ones.
// - Port enables have selectable polarity so decoded upper address bits can pick one of up to 16 blocks.
// - Cascaded blocks share write address, write data, write enable, read address, read data and read enable.
// - One block in FIFO mode is 4,096 entries deep.
// - Two cascaded blocks in FIFO mode form one buffer 8,192 entries deep.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "drf_regs.vh"

module drf_fifo_block #(
  parameter integer DATA_W    = 1,
  parameter integer CASC_BITS = 0,
  parameter integer AF_THRESH = 4000,
  parameter integer AE_THRESH = 96
) (
  input  wire                          CLK,
  input  wire                          RESET_N,
  input  wire                          PSEL,
  input  wire                          PENABLE,
  input  wire                          PWRITE,
  input  wire [7:0]                    PADDR,
  input  wire [31:0]                   PWDATA,
  output reg  [31:0]                   PRDATA,
  output reg                           PREADY,
  output reg                           PSLVERR,
  output reg                           IRQ,
  input  wire                          WR_EN,
  input  wire                          WR_BLK_SEL,
  input  wire [`DRF_BLK_AW+CASC_BITS-1:0] WR_ADDR,
  input  wire [DATA_W-1:0]             WR_DATA_BUS,
  output reg                           FULL,
  output reg                           ALMOST_FULL_FLAG,
  input  wire                          RD_CLK,
  input  wire                          RD_EN,
  input  wire                          RD_BLK_SEL,
  input  wire [`DRF_BLK_AW+CASC_BITS-1:0] RD_ADDR,
  output reg  [DATA_W-1:0]             RD_DATA,
  output reg                           EMPTY,
  output reg                           ALMOST_EMPTY_FLAG
);

  localparam integer AW    = `DRF_BLK_AW + CASC_BITS;
  localparam integer DEPTH = `DRF_BLK_DEPTH << CASC_BITS;
  localparam [AW:0]  AF_LVL = AF_THRESH[AW:0];
  localparam [AW:0]  AE_LVL = AE_THRESH[AW:0];

  function [AW:0] bin2gray;
    input [AW:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [AW:0] gray2bin;
    input [AW:0] g;
    integer i;
    begin
      gray2bin[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // shared array of the cascade; one block holds 4096 entries of the 4608 bits
  reg [DATA_W-1:0] mem [0:DEPTH-1];

  // software state, all in the CLK (write) domain
  reg [`DRF_CTRL_W-1:0] ctrl;
  reg [`DRF_IRQ_W-1:0]  int_stat;
  reg [`DRF_IRQ_W-1:0]  int_mask;

  wire fifo_mode = ctrl[`DRF_CTRL_FIFO_BIT];
  wire fifo_clr  = ctrl[`DRF_CTRL_CLR_BIT];

  // clear acts asynchronously; release lines up with CLK since ctrl is a CLK flop
  wire wr_rst_n = RESET_N & ~fifo_clr;

  // ---------------- write domain ----------------
  reg  [AW:0] wptr;
  reg  [AW:0] wgray;
  reg  [AW:0] rgray_s1;
  reg  [AW:0] rgray_s2;
  wire [AW:0] rbin_w = gray2bin(rgray_s2);

  // enable polarity lets a decoded upper address bit select this block
  wire wr_sel  = WR_EN & (WR_BLK_SEL ^ ctrl[`DRF_CTRL_WPOL_BIT]);
  wire wr_push = wr_sel & fifo_mode & ~FULL;
  wire wr_ovf  = wr_sel & fifo_mode & FULL;

  wire [AW:0] next_wptr  = wptr + {{AW{1'b0}}, wr_push};
  wire [AW:0] next_wgray = bin2gray(next_wptr);
  wire [AW:0] wr_fill    = next_wptr - rbin_w;
  wire        next_full  = (next_wgray == {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});

  // FIFO address replaces the user address through the mux
  wire [AW-1:0] wr_mem_addr = fifo_mode ? wptr[AW-1:0] : WR_ADDR;
  wire          wr_do       = fifo_mode ? wr_push : wr_sel;

  always @(posedge CLK) begin
    if (wr_do) begin
      mem[wr_mem_addr] <= WR_DATA_BUS;
    end
  end

  always @(posedge CLK or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wptr             <= {(AW+1){1'b0}};
      wgray            <= {(AW+1){1'b0}};
      rgray_s1         <= {(AW+1){1'b0}};
      rgray_s2         <= {(AW+1){1'b0}};
      FULL             <= 1'b0;
      ALMOST_FULL_FLAG <= 1'b0;
    end else begin
      rgray_s1         <= rgray;
      rgray_s2         <= rgray_s1;
      wptr             <= next_wptr;
      wgray            <= next_wgray;
      FULL             <= fifo_mode & next_full;
      ALMOST_FULL_FLAG <= fifo_mode & (wr_fill >= AF_LVL);
    end
  end

  // ---------------- read domain ----------------
  // clear and reset assert at once, release is synchronised to RD_CLK
  reg  rd_rst_s1;
  reg  rd_rst_n;
  wire rd_arst_n = RESET_N & ~fifo_clr;

  always @(posedge RD_CLK or negedge rd_arst_n) begin
    if (!rd_arst_n) begin
      rd_rst_s1 <= 1'b0;
      rd_rst_n  <= 1'b0;
    end else begin
      rd_rst_s1 <= 1'b1;
      rd_rst_n  <= rd_rst_s1;
    end
  end

  // mode bits are levels set while idle; two flops each
  reg [2:0] cfg_s1;
  reg [2:0] cfg_s2;
  wire rd_fifo = cfg_s2[0];
  wire rd_pipe = cfg_s2[1];
  wire rd_pol  = cfg_s2[2];

  reg  [AW:0] rptr;
  reg  [AW:0] rgray;
  reg  [AW:0] wgray_s1;
  reg  [AW:0] wgray_s2;
  wire [AW:0] wbin_r = gray2bin(wgray_s2);

  wire rd_sel = RD_EN & (RD_BLK_SEL ^ rd_pol);
  wire rd_pop = rd_sel & rd_fifo & ~EMPTY;
  wire rd_unf = rd_sel & rd_fifo & EMPTY;

  wire [AW:0] next_rptr  = rptr + {{AW{1'b0}}, rd_pop};
  wire [AW:0] next_rgray = bin2gray(next_rptr);
  wire [AW:0] rd_fill    = wbin_r - next_rptr;

  wire [AW-1:0]     rd_mem_addr = rd_fifo ? rptr[AW-1:0] : RD_ADDR;
  wire              rd_do       = rd_fifo ? rd_pop : rd_sel;
  wire [DATA_W-1:0] rd_raw      = mem[rd_mem_addr];

  reg [DATA_W-1:0] rd_stage;
  reg              unf_tgl;

  always @(posedge RD_CLK or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      cfg_s1            <= 3'h0;
      cfg_s2            <= 3'h0;
      rptr              <= {(AW+1){1'b0}};
      rgray             <= {(AW+1){1'b0}};
      wgray_s1          <= {(AW+1){1'b0}};
      wgray_s2          <= {(AW+1){1'b0}};
      EMPTY             <= 1'b1;
      ALMOST_EMPTY_FLAG <= 1'b1;
      rd_stage          <= {DATA_W{1'b0}};
      RD_DATA           <= {DATA_W{1'b0}};
      unf_tgl           <= 1'b0;
    end else begin
      cfg_s1   <= {ctrl[`DRF_CTRL_RPOL_BIT], ctrl[`DRF_CTRL_PIPE_BIT], fifo_mode};
      cfg_s2   <= cfg_s1;
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
      rptr     <= next_rptr;
      rgray    <= next_rgray;
      // in RAM mode the FIFO flags sit at their idle values
      EMPTY             <= ~rd_fifo | (next_rgray == wgray_s2);
      ALMOST_EMPTY_FLAG <= ~rd_fifo | (rd_fill <= AE_LVL);
      if (rd_do) begin
        rd_stage <= rd_raw;
      end
      // pipelined output adds one register after the array read
      if (rd_pipe) begin
        RD_DATA <= rd_stage;
      end else if (rd_do) begin
        RD_DATA <= rd_raw;
      end
      if (rd_unf) begin
        unf_tgl <= ~unf_tgl;
      end
    end
  end

  // ---------------- underflow event back to CLK ----------------
  reg unf_s1;
  reg unf_s2;
  reg unf_s3;
  reg full_d;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      unf_s1 <= 1'b0;
      unf_s2 <= 1'b0;
      unf_s3 <= 1'b0;
      full_d <= 1'b0;
    end else begin
      unf_s1 <= unf_tgl;
      unf_s2 <= unf_s1;
      unf_s3 <= unf_s2;
      full_d <= FULL;
    end
  end

  // the unf_s* flops survive clear because they sit on RESET_N only;
  // a clear resets unf_tgl, which may show one spurious underflow event
  wire unf_evt  = unf_s2 ^ unf_s3;
  wire full_evt = FULL & ~full_d;

  // EMPTY status seen from CLK; a level, so two flops are enough
  reg [1:0] emp_s1;
  reg [1:0] emp_s2;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      emp_s1 <= 2'b11;
      emp_s2 <= 2'b11;
    end else begin
      emp_s1 <= {ALMOST_EMPTY_FLAG, EMPTY};
      emp_s2 <= emp_s1;
    end
  end

  // ---------------- APB slave ----------------
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr    = PSEL & PENABLE & PWRITE & PREADY;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `DRF_CTRL_OFF) || (a == `DRF_STATUS_OFF) ||
               (a == `DRF_INT_STAT_OFF) || (a == `DRF_INT_MASK_OFF);
    end
  endfunction

  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    case (PADDR)
      `DRF_CTRL_OFF: begin
        next_prdata[`DRF_CTRL_W-1:0] = ctrl;
      end
      `DRF_STATUS_OFF: begin
        next_prdata[`DRF_ST_FULL_BIT]   = FULL;
        next_prdata[`DRF_ST_EMPTY_BIT]  = emp_s2[0];
        next_prdata[`DRF_ST_ALMOST_FULL_FLAG_BIT]  = ALMOST_FULL_FLAG;
        next_prdata[`DRF_ST_ALMOST_EMPTY_FLAG_BIT] = emp_s2[1];
      end
      `DRF_INT_STAT_OFF: begin
        next_prdata[`DRF_IRQ_W-1:0] = int_stat;
      end
      `DRF_INT_MASK_OFF: begin
        next_prdata[`DRF_IRQ_W-1:0] = int_mask;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  wire [`DRF_IRQ_W-1:0] irq_set = {full_evt, unf_evt, wr_ovf};
  wire [`DRF_IRQ_W-1:0] irq_clr =
    (apb_wr && PADDR == `DRF_INT_STAT_OFF) ? PWDATA[`DRF_IRQ_W-1:0] : {`DRF_IRQ_W{1'b0}};
  // a new event beats a write-one-to-clear in the same cycle
  wire [`DRF_IRQ_W-1:0] next_int_stat = (int_stat & ~irq_clr) | irq_set;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl     <= `DRF_CTRL_RST;
      int_stat <= `DRF_IRQ_RST;
      int_mask <= `DRF_IRQ_RST;
      PRDATA   <= 32'h0000_0000;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      // zero wait state: ready in the first access cycle only
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup & ~mapped(PADDR);
      if (apb_setup && !PWRITE) begin
        PRDATA <= next_prdata;
      end
      if (apb_wr && PADDR == `DRF_CTRL_OFF) begin
        ctrl <= PWDATA[`DRF_CTRL_W-1:0];
      end
      if (apb_wr && PADDR == `DRF_INT_MASK_OFF) begin
        int_mask <= PWDATA[`DRF_IRQ_W-1:0];
      end
      int_stat <= next_int_stat;
      IRQ      <= |(next_int_stat & int_mask);
    end
  end

  // port clocks are independent; each may run to `DRF_MAX_PORT_MHZ

endmodule // drf_fifo_block

`default_nettype wire

/* File: tb/drf_fifo_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module drf_fifo_asserts (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FULL,
  input wire logic        ALMOST_FULL_FLAG,
  input wire logic        WR_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_cause_a: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
    else $error("ready without setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (PREADY && PADDR > 8'h0C |-> PSLVERR)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PREADY && PADDR <= 8'h0C && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  err_data_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  full_has_af_a: assert property (FULL |-> ALMOST_FULL_FLAG)
    else $error("full without almost full");
  full_rise_a: assert property ($rose(FULL) |-> $past(WR_EN))
    else $error("full rose without a write");
endmodule // drf_fifo_asserts

bind drf_fifo_block drf_fifo_asserts chk_u (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .FULL(FULL), .ALMOST_FULL_FLAG(ALMOST_FULL_FLAG), .WR_EN(WR_EN));
`default_nettype wire

/* File: tb/drf_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module drf_reader #(parameter int DW = 8) (
  output logic               rd_clk,
  output logic               rd_en,
  output logic               rd_blk_sel,
  output logic [11:0]        rd_addr,
  input  wire logic [DW-1:0] rd_data,
  input  wire logic          empty
);
  // value seen one edge before d is taken; shows the pipeline lag
  logic [DW-1:0] early;
  initial begin
    rd_clk = 1'b0;
    forever #3.5 rd_clk = ~rd_clk;
  end
  initial begin
    rd_en = 1'b0;
    rd_blk_sel = 1'b1;
    rd_addr = 12'hFFF;
  end
  // honour low reads an empty fifo on purpose
  task automatic read_word(input logic [11:0] a, input bit honour, output logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge rd_clk);
    while (honour && empty !== 1'b0 && n < 200) begin
      @(posedge rd_clk);
      n++;
    end
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge rd_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge rd_clk);
    early = rd_data;
    @(posedge rd_clk);
    d = rd_data;
  endtask
  task automatic set_sel(input logic s);
    @(posedge rd_clk);
    rd_blk_sel <= s;
  endtask
endmodule // drf_reader
`default_nettype wire

/* File: tb/drf_fifo_block_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drf_regs.vh"
module drf_fifo_block_bench;
  logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, WR_EN, err;
  logic        WR_BLK_SEL;
  logic        FULL, ALMOST_FULL_FLAG, RD_CLK, RD_EN, RD_BLK_SEL, EMPTY, ALMOST_EMPTY_FLAG;
  logic [7:0]  PADDR, WR_DATA_BUS, RD_DATA, rd;
  logic [11:0] WR_ADDR, RD_ADDR;
  logic [31:0] PWDATA, PRDATA, rv;
  int          fails, comparisons;
  drf_fifo_block #(.DATA_W(8), .CASC_BITS(0), .AF_THRESH(4000), .AE_THRESH(96)) dut_u (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .WR_EN(WR_EN), .WR_BLK_SEL(WR_BLK_SEL), .WR_ADDR(WR_ADDR),
    .WR_DATA_BUS(WR_DATA_BUS), .FULL(FULL), .ALMOST_FULL_FLAG(ALMOST_FULL_FLAG),
    .RD_CLK(RD_CLK), .RD_EN(RD_EN), .RD_BLK_SEL(RD_BLK_SEL), .RD_ADDR(RD_ADDR),
    .RD_DATA(RD_DATA), .EMPTY(EMPTY), .ALMOST_EMPTY_FLAG(ALMOST_EMPTY_FLAG));
  drf_reader #(.DW(8)) p_u (.rd_clk(RD_CLK), .rd_en(RD_EN), .rd_blk_sel(RD_BLK_SEL),
    .rd_addr(RD_ADDR), .rd_data(RD_DATA), .empty(EMPTY));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // ends once PREADY is seen high; the watchdog only ends a wait that never sees it
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rv = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic push(input int cnt, input logic [11:0] a, input logic [7:0] base);
    for (int i = 0; i < cnt; i++) begin
      @(posedge CLK);
      WR_EN <= 1'b1;
      WR_ADDR <= a;
      WR_DATA_BUS <= base + i[7:0];
    end
    @(posedge CLK);
    WR_EN <= 1'b0;
    WR_DATA_BUS <= ~WR_DATA_BUS;
  endtask
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    summarize();
  end
  initial begin
    {RESET_N, PSEL, PENABLE, PWRITE, WR_EN} = 5'h00;
    {PADDR, WR_DATA_BUS, WR_ADDR, PWDATA} = '0;
    WR_BLK_SEL = 1'b1;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (10) @(posedge CLK);
    chk("full", 0, FULL);
    chk("empty", 1, EMPTY);
    apb(0, `DRF_CTRL_OFF, 0); chk("ctrl", 0, rv);
    apb(0, 8'h10, 0); chk("slverr", 1, err);
    chk("bad read", 0, rv);
    push(1, 12'h005, 8'hA5);
    push(1, 12'h006, 8'h3C);
    p_u.read_word(12'h005, 0, rd); chk("ram 5", 8'hA5, rd);
    p_u.read_word(12'h006, 0, rd); chk("ram 6", 8'h3C, rd);
    apb(1, `DRF_CTRL_OFF, 32'h2);
    repeat (10) @(posedge CLK);
    p_u.read_word(12'h006, 0, rd); chk("pipe 6", 8'h3C, rd);
    p_u.read_word(12'h005, 0, rd); chk("pipe 5", 8'hA5, rd);
    chk("pipe lag", 8'h3C, p_u.early);
    WR_BLK_SEL <= 1'b0;
    push(1, 12'h005, 8'h11);
    apb(1, `DRF_CTRL_OFF, 32'hC);
    repeat (10) @(posedge CLK);
    push(1, 12'h006, 8'h5A);
    p_u.set_sel(1'b0);
    p_u.read_word(12'h006, 0, rd); chk("wsel pol", 8'h5A, rd);
    p_u.read_word(12'h005, 0, rd); chk("wsel off", 8'hA5, rd);
    WR_BLK_SEL <= 1'b1;
    p_u.set_sel(1'b1);
    apb(1, `DRF_CTRL_OFF, 1);
    apb(1, `DRF_INT_MASK_OFF, 1);
    repeat (10) @(posedge CLK);
    push(4095, 12'hABC, 8'h00);
    repeat (2) @(posedge CLK);
    chk("not full", 0, FULL);
    chk("almost_full_flag", 1, ALMOST_FULL_FLAG);
    push(1, 12'h000, 8'hFF);
    @(posedge CLK);
    chk("full", 1, FULL);
    push(1, 12'h000, 8'h77);
    apb(0, `DRF_STATUS_OFF, 0); chk("status", 32'h5, rv);
    apb(0, `DRF_INT_STAT_OFF, 0); chk("int", 32'h5, rv);
    chk("irq", 1, IRQ);
    apb(1, `DRF_INT_STAT_OFF, 1);
    apb(0, `DRF_INT_STAT_OFF, 0); chk("int w1c", 32'h4, rv);
    chk("irq off", 0, IRQ);
    p_u.read_word(12'h005, 1, rd); chk("fifo 0", 8'h00, rd);
    p_u.read_word(12'h005, 1, rd); chk("fifo 1", 8'h01, rd);
    repeat (10) @(posedge CLK);
    chk("full gone", 0, FULL);
    apb(1, `DRF_CTRL_OFF, 32'h11);
    apb(1, `DRF_CTRL_OFF, 1);
    repeat (10) @(posedge CLK);
    apb(0, `DRF_STATUS_OFF, 0); chk("cleared", 32'hA, rv);
    apb(1, `DRF_INT_STAT_OFF, 7);
    p_u.read_word(12'h000, 0, rd);
    repeat (10) @(posedge CLK);
    apb(0, `DRF_INT_STAT_OFF, 0); chk("underflow", 32'h2, rv);
    summarize();
  end
endmodule // drf_fifo_block_bench
`default_nettype wire
